/* File: hw/ovfr_top.sv */
// Output overvoltage fault response sequencer with its response register
`default_nettype none
// Functional notes
// RULE1 - Response 00: fault ignored, output keeps running.
// RULE2 - Response 01: run for delay, then apply retry setting if fault persists.
// RULE3 - Response 10: disable output at once, then apply retry setting.
// RULE4 - Response 11: output off while fault present, back on when gone.
// RULE5 - Latched fault cleared by status clear, clear-all, reset or off/on cycle.
// RULE6 - Retry 000: no restart, output stays off until cleared.
// RULE7 - Retry 001..011: one to three restarts, then off until cleared.
// RULE8 - Retry 111: restart attempts without limit.
// RULE9 - Restart spacing equals delay count times fault time unit (with delay code 0 the code spaces restarts two units apart).
// RULE10 - Retry 100..110: four to six restarts, then off until cleared.
// RULE11 - Delay field n means 2 to the n time units.
// RULE12 - Endless retry stops on commanded off or another shutdown fault.
// RULE13 - Attempt counter and timer restart on clear or commanded off.
module ovfr_top
  import ovfr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic       clk_en_i,
  // Register write port
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  // Fault and control inputs
  input  wire logic       ov_fault_i,
  input  wire logic       unit_tick_i,
  input  wire logic       status_clr_i,
  input  wire logic       clear_faults_i,
  input  wire logic       output_on_cmd_i,
  input  wire logic       other_shutdown_i,
  // Outputs
  output logic [7:0]      action_o,
  output logic            output_en_o,
  output logic            fault_latched_o,
  output logic [2:0]      state_o
);

  typedef struct packed {
    logic [7:0]            action;
    ovfr_state_t           st;
    logic [OVFR_CNT_W-1:0] units;
    logic [2:0]            tries;
    logic                  latched;
    logic                  on_q;
    logic                  en;
  } ovfr_regs_t;

  ovfr_regs_t r, next_r;

  // Number of time units for a delay code
  function automatic logic [OVFR_CNT_W-1:0] ovfr_units(input logic [2:0] code);
    ovfr_units = OVFR_CNT_W'(1) << code; // see RULE11
  endfunction

  logic [1:0] resp;
  logic [2:0] retry;
  logic [2:0] dly;
  logic       cleared;
  logic       expired;

  assign resp  = r.action[OVFR_RESP_MSB:OVFR_RESP_LSB];
  assign retry = r.action[OVFR_RETRY_MSB:OVFR_RETRY_LSB];
  assign dly   = r.action[OVFR_DELAY_MSB:OVFR_DELAY_LSB];
  // Off/on through the control input also clears
  assign cleared = status_clr_i | clear_faults_i | (output_on_cmd_i & ~r.on_q); // see RULE5
  assign expired = unit_tick_i && (r.units + OVFR_CNT_W'(1) >= ovfr_units(dly)); // see RULE9

  // ***********************************
  // Next-state logic
  // ***********************************
  always_comb begin
    next_r = r;
    next_r.on_q = output_on_cmd_i;
    if (reg_wr_i && reg_addr_i == OVFR_REG_ACTION) begin
      next_r.action = reg_wdata_i;
    end
    if (unit_tick_i) begin
      next_r.units = r.units + OVFR_CNT_W'(1);
    end
    case (r.st)
      OVFR_RUN: begin
        next_r.units = '0;
        next_r.tries = '0;
        if (ov_fault_i) begin
          if (resp == OVFR_RESP_DELAY) begin
            next_r.st = OVFR_DELAY; // see RULE2
          end else if (resp == OVFR_RESP_DISABLE) begin
            next_r.st = OVFR_OFF; // see RULE3
            next_r.latched = 1'b1;
          end else if (resp == OVFR_RESP_UNTIL) begin
            next_r.st = OVFR_HOLD; // see RULE4
          end
        end
      end
      OVFR_DELAY: begin
        if (!ov_fault_i) begin
          next_r.st = OVFR_RUN;
        end else if (expired) begin
          next_r.st = OVFR_OFF; // see RULE2
          next_r.units = '0;
          next_r.latched = 1'b1;
        end
      end
      OVFR_OFF: begin
        if (retry == OVFR_RETRY_NONE ||
            (retry != OVFR_RETRY_FOREVER && r.tries >= retry)) begin
          next_r.st = OVFR_LATCHED; // see RULE6, see RULE7, see RULE10
        end else if (expired) begin
          next_r.st = OVFR_RESTART; // see RULE8, see RULE9
          next_r.units = '0;
          if (retry != OVFR_RETRY_FOREVER) begin
            next_r.tries = r.tries + 3'h1;
          end
        end
      end
      OVFR_RESTART: begin
        // Attempt runs one time unit before judging it
        // Timer keeps running into OFF so spacing is start to start
        if (ov_fault_i && unit_tick_i) begin
          next_r.st = OVFR_OFF; // see RULE9
        end else if (!ov_fault_i && unit_tick_i) begin
          next_r.st = OVFR_RUN;
          next_r.latched = 1'b0;
        end
      end
      OVFR_HOLD: begin
        if (!ov_fault_i) begin
          next_r.st = OVFR_RUN; // see RULE4
        end
      end
      default: begin
        next_r.st = OVFR_LATCHED;
      end
    endcase
    // Commanded off, clear or other shutdown aborts the sequence
    // Fault latching in the same cycle as a clear wins
    if (!output_on_cmd_i || other_shutdown_i ||
        (cleared && !(next_r.latched && !r.latched))) begin
      next_r.st = OVFR_RUN; // see RULE12, see RULE13
      next_r.units = '0;
      next_r.tries = '0;
      next_r.latched = 1'b0;
    end
    next_r.en = output_on_cmd_i && !other_shutdown_i &&
                (next_r.st == OVFR_RUN || next_r.st == OVFR_DELAY ||
                 next_r.st == OVFR_RESTART); // see RULE1
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      r <= '0; // see RULE5
      r.action <= OVFR_ACTION_RESET;
      r.st <= OVFR_RUN;
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

  assign action_o        = r.action;
  assign output_en_o     = r.en;
  assign fault_latched_o = r.latched;
  assign state_o         = r.st;

  // ***********************************
  // Assertions
  // ***********************************
  property p_ignore;
    @(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && r.st == OVFR_RUN && resp == OVFR_RESP_IGNORE && output_on_cmd_i &&
     !other_shutdown_i && !reg_wr_i) |=> r.en;
  endproperty
  a_ignore: assert property (p_ignore) else $error("output dropped in ignore mode"); // see RULE1

  property p_disable;
    @(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && r.st == OVFR_RUN && ov_fault_i && resp == OVFR_RESP_DISABLE &&
     output_on_cmd_i && !cleared && !other_shutdown_i) |=> !r.en;
  endproperty
  a_disable: assert property (p_disable) else $error("output not cut at fault"); // see RULE3

  property p_hold;
    @(posedge core_clk_i) disable iff (srst_i)
    (r.st == OVFR_HOLD) |-> !r.en;
  endproperty
  a_hold: assert property (p_hold) else $error("output on during hold"); // see RULE4

  property p_offcmd;
    @(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && !output_on_cmd_i) |=> (r.st == OVFR_RUN && !r.en && r.tries == 3'h0);
  endproperty
  a_offcmd: assert property (p_offcmd) else $error("sequence not reset on off"); // see RULE13

  property p_noretry;
    @(posedge core_clk_i) disable iff (srst_i)
    (r.st == OVFR_RESTART) |-> (retry != OVFR_RETRY_NONE);
  endproperty
  a_noretry: assert property (p_noretry) else $error("restart with retry zero"); // see RULE6

  property p_count;
    @(posedge core_clk_i) disable iff (srst_i)
    (retry != OVFR_RETRY_FOREVER) |-> (r.tries <= retry);
  endproperty
  a_count: assert property (p_count) else $error("too many restarts"); // see RULE7

  property p_clear;
    @(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && clear_faults_i && r.latched) |=> !r.latched;
  endproperty
  a_clear: assert property (p_clear) else $error("clear-all left fault latched"); // see RULE5

  property p_latched_off;
    @(posedge core_clk_i) disable iff (srst_i)
    (r.st == OVFR_LATCHED) |-> !r.en;
  endproperty
  a_latched_off: assert property (p_latched_off) else $error("latched but on"); // see RULE10

  property p_retry_limit;
    @(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && r.st == OVFR_OFF && retry != OVFR_RETRY_FOREVER && r.tries >= retry &&
     output_on_cmd_i && !cleared && !other_shutdown_i) |=> (r.st == OVFR_LATCHED);
  endproperty
  a_retry_limit: assert property (p_retry_limit) else $error("restart beyond limit"); // see RULE7

  c_delay: cover property (@(posedge core_clk_i) r.st == OVFR_DELAY ##1 r.st == OVFR_OFF);
  c_restart: cover property (@(posedge core_clk_i) r.st == OVFR_RESTART ##1 r.st == OVFR_RUN);
  c_latch: cover property (@(posedge core_clk_i) r.st == OVFR_OFF ##1 r.st == OVFR_LATCHED);

endmodule
`default_nettype wire

/* File: hw/ovfr_pkg.sv */
// Constants and types for the output overvoltage fault response block
`default_nettype none
package ovfr_pkg;
  // Command code of the response register
  localparam logic [7:0] OVFR_REG_ACTION   = 8'h41;
  // Response register value after reset
  localparam logic [7:0] OVFR_ACTION_RESET = 8'h80;
  // Field positions
  localparam int OVFR_RESP_MSB  = 7;
  localparam int OVFR_RESP_LSB  = 6;
  localparam int OVFR_RETRY_MSB = 5;
  localparam int OVFR_RETRY_LSB = 3;
  localparam int OVFR_DELAY_MSB = 2;
  localparam int OVFR_DELAY_LSB = 0;
  // Response encodings
  localparam logic [1:0] OVFR_RESP_IGNORE  = 2'h0;
  localparam logic [1:0] OVFR_RESP_DELAY   = 2'h1;
  localparam logic [1:0] OVFR_RESP_DISABLE = 2'h2;
  localparam logic [1:0] OVFR_RESP_UNTIL   = 2'h3;
  // Retry encodings
  localparam logic [2:0] OVFR_RETRY_NONE   = 3'h0;
  localparam logic [2:0] OVFR_RETRY_FOREVER = 3'h7;
  // Width of the unit count (delay up to 128 units)
  localparam int OVFR_CNT_W = 8;

  typedef enum logic [2:0] {
    OVFR_RUN     = 3'b000,
    OVFR_DELAY   = 3'b001,
    OVFR_OFF     = 3'b011,
    OVFR_RESTART = 3'b010,
    OVFR_LATCHED = 3'b110,
    OVFR_HOLD    = 3'b111
  } ovfr_state_t;
endpackage
`default_nettype wire

/* File: bench/ovfr_host.sv */
// Host and time-unit model facing the fault response block
`default_nettype none
module ovfr_host (
  // Clock
  input  wire logic       clk_i,
  // Host side
  output logic            wr_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o,
  output logic            tick_o,
  output logic            sclr_o,
  output logic            cflt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div = 2'h0;
  initial begin
    {wr_o, addr_o, wdata_o, sclr_o, cflt_o} = '0;
  end
  // Time unit of four cycles
  always @(negedge clk_i) begin
    div <= div + 2'h1;
    tick_o <= (div == 2'h3);
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clk_i);
    {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
  endtask
  // Status bit clear or clear-all pulse
  task automatic clr(input logic all);
    @(negedge clk_i);
    if (all) cflt_o = 1'b1; else sclr_o = 1'b1;
    @(negedge clk_i);
    {cflt_o, sclr_o} = 2'b00;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking testbench of the fault response block
`default_nettype none
module tb;
  import ovfr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, ce = 1, fault = 0, on_cmd = 1, oth = 0, pe = 0;
  wire logic wr, tick, sclr, cflt;
  wire logic [7:0] addr, wdata;
  logic [7:0] action, v;
  logic oen, lat;
  logic [2:0] st;
  int n_fail = 0, n_tests = 0, rises = 0, dt = 0, d;
  always #2 clk = ~clk;
  ovfr_host ovfr_host_inst (.clk_i(clk), .wr_o(wr), .addr_o(addr), .wdata_o(wdata),
    .tick_o(tick), .sclr_o(sclr), .cflt_o(cflt));
  ovfr_top ovfr_top_inst (.core_clk_i(clk), .srst_i(srst), .clk_en_i(ce), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .ov_fault_i(fault), .unit_tick_i(tick),
    .status_clr_i(sclr), .clear_faults_i(cflt), .output_on_cmd_i(on_cmd),
    .other_shutdown_i(oth), .action_o(action), .output_en_o(oen),
    .fault_latched_o(lat), .state_o(st));
  always @(posedge clk) begin
    if (oen === 1'b1 && pe === 1'b0) rises++;
    if (tick && st === OVFR_DELAY) dt++;
    pe <= oen;
  end
  function automatic int units(input int code);
    return 1 << code;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
  // ***************
  // Main sequence
  // ***************
  initial begin
    void'($urandom(32'hf62b));
    cyc(2);
    srst = 0;
    chk(action, OVFR_ACTION_RESET);
    v = 8'($urandom);
    ovfr_host_inst.wr(8'h40, v);
    cyc(1);
    chk(action, OVFR_ACTION_RESET);
    chk({7'h0, oen}, 8'h01);
    ovfr_host_inst.wr(OVFR_REG_ACTION, {2'b00, 6'($urandom)});
    {rises, fault} = {32'd0, 1'b1};
    cyc(100);
    chk(8'(rises), 8'h00);
    chk({7'h0, oen}, 8'h01);
    ovfr_host_inst.wr(OVFR_REG_ACTION, {2'b11, 6'($urandom)});
    cyc(3);
    chk({7'h0, oen}, 8'h00);
    fault = 0;
    cyc(3);
    chk({7'h0, oen}, 8'h01);
    for (int r = 0; r < 8; r++) begin
      v = {2'b10, 3'(r), 3'($urandom % 2)};
      ovfr_host_inst.wr(OVFR_REG_ACTION, v);
      cyc(1);
      chk(action, v);
      {rises, fault} = {32'd0, 1'b1};
      cyc(240);
      if (r == 7) begin
        chk({7'h0, rises > 7}, 8'h01);
        on_cmd = 0;
        cyc(2);
        rises = 0;
        cyc(40);
        chk(8'(rises), 8'h00);
      end else begin
        chk(8'(rises), 8'(r));
        fault = 0;
        cyc(20);
        chk({7'h0, oen}, 8'h00);
        chk({7'h0, lat}, 8'h01);
        chk({5'h0, st}, {5'h0, OVFR_LATCHED});
        if (r % 3 == 2) on_cmd = 0;
        else ovfr_host_inst.clr(1'(r % 3));
      end
      cyc(2);
      {fault, on_cmd} = 2'b01;
      cyc(3);
      chk({7'h0, oen}, 8'h01);
      chk({7'h0, lat}, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      d = i;
      ovfr_host_inst.wr(OVFR_REG_ACTION, {2'b01, 3'h0, 3'(d)});
      {dt, fault} = {32'd0, 1'b1};
      cyc(units(d) * 4 + 12);
      chk(8'(dt), 8'(units(d)));
      chk({7'h0, oen}, 8'h00);
      fault = 0;
      ovfr_host_inst.clr(1'b1);
      cyc(3);
    end
    // Other shutdown ends endless retrying
    ovfr_host_inst.wr(OVFR_REG_ACTION, {2'b10, OVFR_RETRY_FOREVER, 3'($urandom % 2)});
    fault = 1;
    cyc(40);
    oth = 1;
    cyc(2);
    rises = 0;
    cyc(20);
    chk(8'(rises), 8'h00);
    chk({7'h0, oen}, 8'h00);
    {fault, oth} = 2'b00;
    cyc(3);
    chk({7'h0, oen}, 8'h01);
    // Reset in mid-run clears a latched fault
    ovfr_host_inst.wr(OVFR_REG_ACTION, 8'h81);
    fault = 1;
    cyc(3);
    chk({7'h0, lat}, 8'h01);
    fault = 0;
    srst = 1;
    cyc(1);
    srst = 0;
    cyc(1);
    chk(action, OVFR_ACTION_RESET);
    chk({6'h0, lat, oen}, 8'h01);
    // Clock enable low freezes the sequencer
    ce = 0;
    fault = 1;
    cyc(5);
    chk({5'h0, st}, {5'h0, OVFR_RUN});
    ce = 1;
    cyc(3);
    chk({5'h0, st}, {5'h0, OVFR_LATCHED});
    chk({7'h0, oen}, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
